// *** shared/fpe_link_if.sv ***
// Serial link between the flash host controller and the flash device
`timescale 1ns/1ps
`default_nettype none
interface fpe_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	modport dev (input sclk, input cs_n, input mosi, output miso);
	modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// *** shared/fpe_pkg.sv ***
// Shared constants and types for the flash protect/program/erase link
package fpe_pkg;
	localparam int CLK_NS = 10;
	localparam logic [23:0] ARRAY_BYTES = 24'h800000;
	localparam logic [22:0] ARRAY_LAST = 23'h7FFFFF;
	localparam logic [6:0] BLK_BOTTOM = 7'h00;
	localparam logic [6:0] BLK_TOP = 7'h7F;
	localparam int BLOCK_LOCKS = 126;
	localparam int SECTOR_LOCKS = 32;
	localparam int SECT_PER_BLK = 16;
	localparam int LOCK_N = BLOCK_LOCKS + SECTOR_LOCKS;
	localparam logic [9:0] DATA_FIRST = 10'h004;
	localparam logic [9:0] PAGE_BYTES = 10'h100;
	localparam logic [9:0] DATA_END = DATA_FIRST + PAGE_BYTES;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	localparam logic [7:0] ERASE_FILL = 8'hFF;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_FOUR_K_WIPE = 8'h20;
	localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
	localparam logic [7:0] OP_CHIP_WIPE = 8'hC7;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_SLEEP_ENTER = 8'hB9;
	localparam logic [7:0] OP_SLEEP_EXIT = 8'hAB;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam int SR1_BUSY = 0;
	localparam int SR1_LATCH = 1;
	localparam int SR1_PROT_LSB = 2;
	localparam int SR2_INV = 6;
	localparam int SR3_LOCK_SEL = 2;
	localparam logic [4:0] PROT_RST = 5'h00;
	localparam int T_PROG_NS = 2000;
	localparam int T_ERASE_NS = 4000;
	localparam int T_SRW_NS = 1000;
	localparam logic [15:0] PROG_CYC = 16'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] ERASE_CYC = 16'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SRW_CYC = 16'((T_SRW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SCLK_HALF = 4'h8;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_RDATA = 3'h3;
	localparam logic [2:0] REG_IRQ_STAT = 3'h4;
	localparam logic [2:0] REG_IRQ_MASK = 3'h5;
	localparam int CTRL_NB_LSB = 8;
	localparam int CTRL_HAS_ADDR = 11;
	localparam int CTRL_AUTO_UNLOCK = 12;
	localparam int CTRL_POLL = 13;
	localparam int CTRL_START = 31;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REFUSED = 1;
	typedef enum logic [1:0] {ER_SECTOR = 2'h0, ER_BLOCK = 2'h1, ER_CHIP = 2'h3} fpe_erase_t;
	typedef enum logic [1:0] {FR_UNLOCK = 2'h0, FR_MAIN = 2'h1, FR_POLL = 2'h3} fpe_frame_t;
	typedef enum logic [1:0] {HS_IDLE = 2'h0, HS_LOW = 2'h1, HS_HIGH = 2'h3, HS_GAP = 2'h2} fpe_hstate_t;
endpackage

// *** src/fpe_flash_dev.sv ***
// Flash device end: protection, program/erase sequencing, busy flag and power modes
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_dev
	import fpe_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h5A // Arbitrary identifier value
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	fpe_link_if.dev link,
	input wire logic [7:0] array_rdata_i,
	output logic [22:0] array_addr_o,
	output logic [7:0] array_wdata_o,
	output logic array_prog_o,
	output logic array_erase_o,
	output logic [1:0] erase_kind_o,
	output logic busy_o,
	output logic latch_o,
	output logic standby_o,
	output logic deep_o
);
	function automatic logic prot_hit(input logic [22:0] lo, input logic [22:0] hi,
		input logic [4:0] p, input logic inv);
		logic [2:0] c;
		logic [4:0] sh;
		logic [23:0] sz;
		logic [23:0] rs;
		logic [23:0] re;
		logic ovl;
		logic enclosed;
		c = p[2:0];
		sh = p[4] ? (5'h0B + {2'h0, (c > 3'h4) ? 3'h4 : c}) : (5'h10 + {2'h0, c});
		sz = 24'h000001 << sh;
		rs = p[3] ? 24'h000000 : ARRAY_BYTES - sz;
		re = p[3] ? sz - 24'h000001 : ARRAY_BYTES - 24'h000001;
		ovl = ({1'b0, lo} <= re) && ({1'b0, hi} >= rs);
		enclosed = ({1'b0, lo} >= rs) && ({1'b0, hi} <= re);
		if (c == 3'h0) begin
			return inv;
		end
		if (c == 3'h7) begin
			return !inv;
		end
		return inv ? !enclosed : ovl;
	endfunction

	function automatic logic [7:0] lock_idx(input logic [22:0] a);
		if (a[22:16] == BLK_BOTTOM) begin
			return {4'h0, a[15:12]};
		end
		if (a[22:16] == BLK_TOP) begin
			return {4'h1, a[15:12]};
		end
		return 8'h1F + {1'b0, a[22:16]};
	endfunction

	function automatic logic lock_hit(input logic [7:0] op, input logic [22:0] a,
		input logic [LOCK_N-1:0] lk);
		if (op == OP_CHIP_WIPE) begin
			return |lk;
		end
		if (op == OP_BLOCK_WIPE && a[22:16] == BLK_BOTTOM) begin
			return |lk[SECT_PER_BLK-1:0];
		end
		if (op == OP_BLOCK_WIPE && a[22:16] == BLK_TOP) begin
			return |lk[2*SECT_PER_BLK-1:SECT_PER_BLK];
		end
		return lk[lock_idx(a)];
	endfunction

	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] mosi_s;
	logic [2:0] bit_q;
	logic [9:0] cnt_q;
	logic [6:0] sh_q;
	logic [7:0] op_q;
	logic [15:0] addr_q;
	logic [2:0][7:0] sw_q;
	logic ok_q;
	logic [22:0] pa_q;
	logic prog_q;
	logic [7:0] wdata_q;
	logic erase_q;
	logic [1:0] kind_q;
	logic [4:0] prot_q;
	logic inv_q;
	logic locksel_q;
	logic [LOCK_N-1:0] lock_q;
	logic busy_q;
	logic [15:0] bcnt_q;
	logic latch_q;
	logic deep_q;
	logic [7:0] tx_q;
	logic miso_q;
	logic standby_q;

	logic rise, fall, cs_low, cs_fall, cs_rise, byte_done, frame_ok, idle_ok, cycle_end;
	logic [7:0] byte_v;
	logic [7:0] cur_op;
	logic [22:0] a_full;
	logic [22:0] lo;
	logic [22:0] hi;
	logic prot_now, chip_prot;
	logic ex_unlock, ex_sleep, ex_wake, ex_prog, ex_sect, ex_blk, ex_chip, ex_srw, ex_lock, ex_free;
	logic [7:0] sr1;

	// Link pins pass two flops; the third stage only serves edge detection
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_s <= 3'h0;
			cs_s <= 3'h7;
			mosi_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], link.sclk};
			cs_s <= {cs_s[1:0], link.cs_n};
			mosi_s <= {mosi_s[0], link.mosi};
		end
	end

	assign rise = sclk_s[1] & ~sclk_s[2];
	assign fall = ~sclk_s[1] & sclk_s[2];
	assign cs_low = ~cs_s[1];
	assign cs_fall = ~cs_s[1] & cs_s[2];
	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign byte_v = {sh_q, mosi_s[1]};
	assign byte_done = rise & cs_low & (bit_q == 3'h7);
	assign cur_op = (cnt_q == 10'h000) ? byte_v : op_q;
	assign a_full = {addr_q[14:0], byte_v};
	assign sr1 = {1'b0, prot_q, latch_q, busy_q};
	assign idle_ok = !busy_q && !deep_q;
	assign frame_ok = cs_rise && (bit_q == 3'h0) && (cnt_q != 10'h000);
	assign cycle_end = busy_q && (bcnt_q == 16'h0001);

	always_comb begin
		lo = a_full;
		hi = a_full;
		if (op_q == OP_FOUR_K_WIPE) begin
			lo = {a_full[22:12], 12'h000};
			hi = {a_full[22:12], 12'hFFF};
		end else if (op_q == OP_BLOCK_WIPE) begin
			lo = {a_full[22:16], 16'h0000};
			hi = {a_full[22:16], 16'hFFFF};
		end
		prot_now = locksel_q ? lock_hit(op_q, a_full, lock_q) : prot_hit(lo, hi, prot_q, inv_q);
		chip_prot = locksel_q ? (|lock_q) : prot_hit(23'h000000, ARRAY_LAST, prot_q, inv_q);
	end

	assign ex_unlock = frame_ok && op_q == OP_WRITE_UNLOCK && cnt_q == 10'h001 && idle_ok;
	assign ex_sleep = frame_ok && op_q == OP_SLEEP_ENTER && cnt_q == 10'h001 && idle_ok;
	assign ex_wake = frame_ok && op_q == OP_SLEEP_EXIT && !busy_q;
	assign ex_prog = frame_ok && op_q == OP_PAGE_WRITE && ok_q && cnt_q > DATA_FIRST;
	assign ex_sect = frame_ok && op_q == OP_FOUR_K_WIPE && ok_q && cnt_q == DATA_FIRST;
	assign ex_blk = frame_ok && op_q == OP_BLOCK_WIPE && ok_q && cnt_q == DATA_FIRST;
	assign ex_chip = frame_ok && op_q == OP_CHIP_WIPE && cnt_q == 10'h001 && idle_ok && latch_q
		&& !chip_prot;
	assign ex_srw = frame_ok && op_q == OP_STATUS_WRITE && idle_ok && latch_q
		&& cnt_q >= 10'h002 && cnt_q <= DATA_FIRST;
	assign ex_lock = frame_ok && op_q == OP_LOCK && cnt_q == DATA_FIRST && idle_ok && latch_q;
	assign ex_free = frame_ok && op_q == OP_UNLOCK && cnt_q == DATA_FIRST && idle_ok && latch_q;

	// Serial framing: bit and byte counters, opcode and address capture
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_q <= 3'h0;
			cnt_q <= 10'h000;
			sh_q <= 7'h00;
			op_q <= 8'h00;
			addr_q <= 16'h0000;
			sw_q <= '0;
		end else if (cs_fall) begin
			bit_q <= 3'h0;
			cnt_q <= 10'h000;
		end else if (rise && cs_low) begin
			sh_q <= byte_v[6:0];
			bit_q <= bit_q + 3'h1;
			if (byte_done) begin
				if (cnt_q != CNT_MAX) begin
					cnt_q <= cnt_q + 10'h001;
				end
				if (cnt_q == 10'h000) begin
					op_q <= byte_v;
				end
				if (cnt_q != 10'h000 && cnt_q < DATA_FIRST) begin
					addr_q <= {addr_q[7:0], byte_v};
					sw_q[cnt_q[1:0] - 2'h1] <= byte_v;
				end
			end
		end
	end

	// Target check at the last address byte; holds for the rest of the frame
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ok_q <= 1'b0;
		end else if (cs_fall) begin
			ok_q <= 1'b0;
		end else if (byte_done && cnt_q == DATA_FIRST - 10'h001) begin
			ok_q <= latch_q && idle_ok && !prot_now;
		end
	end

	// Array address, program strobes and erase strobes
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pa_q <= 23'h000000;
			prog_q <= 1'b0;
			wdata_q <= ERASE_FILL;
			erase_q <= 1'b0;
			kind_q <= ER_SECTOR;
		end else begin
			prog_q <= 1'b0;
			erase_q <= ex_sect || ex_blk || ex_chip;
			if (byte_done && cnt_q == DATA_FIRST - 10'h001) begin
				pa_q <= a_full;
			end else if (prog_q) begin
				pa_q[7:0] <= pa_q[7:0] + 8'h01;
			end else if (ex_sect) begin
				pa_q <= {pa_q[22:12], 12'h000};
				kind_q <= ER_SECTOR;
			end else if (ex_blk) begin
				pa_q <= {pa_q[22:16], 16'h0000};
				kind_q <= ER_BLOCK;
			end else if (ex_chip) begin
				pa_q <= 23'h000000;
				kind_q <= ER_CHIP;
			end
			if (byte_done && op_q == OP_PAGE_WRITE && ok_q && cnt_q >= DATA_FIRST && cnt_q < DATA_END) begin
				prog_q <= 1'b1;
				wdata_q <= array_rdata_i & byte_v;
			end
		end
	end

	// Protection configuration committed by a status write
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prot_q <= PROT_RST;
			inv_q <= 1'b0;
			locksel_q <= 1'b0;
		end else if (ex_srw) begin
			prot_q <= sw_q[0][SR1_PROT_LSB +: 5];
			if (cnt_q >= 10'h003) begin
				inv_q <= sw_q[1][SR2_INV];
			end
			if (cnt_q >= DATA_FIRST) begin
				locksel_q <= sw_q[2][SR3_LOCK_SEL];
			end
		end
	end

	// Individual lock bits; target taken from the address captured at the third address byte
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lock_q <= {LOCK_N{1'b1}};
		end else if (ex_lock) begin
			lock_q[lock_idx(pa_q)] <= 1'b1;
		end else if (ex_free) begin
			lock_q[lock_idx(pa_q)] <= 1'b0;
		end
	end

	// Internal cycle timer
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
			bcnt_q <= 16'h0000;
		end else if (ex_prog) begin
			busy_q <= 1'b1;
			bcnt_q <= PROG_CYC;
		end else if (ex_sect || ex_blk || ex_chip) begin
			busy_q <= 1'b1;
			bcnt_q <= ERASE_CYC;
		end else if (ex_srw) begin
			busy_q <= 1'b1;
			bcnt_q <= SRW_CYC;
		end else if (cycle_end) begin
			busy_q <= 1'b0;
			bcnt_q <= 16'h0000;
		end else if (busy_q) begin
			bcnt_q <= bcnt_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			latch_q <= 1'b0;
		end else if (cycle_end || ex_lock || ex_free) begin
			latch_q <= 1'b0;
		end else if (ex_unlock) begin
			latch_q <= 1'b1;
		end
	end

	// Power modes
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			deep_q <= 1'b0;
			standby_q <= 1'b1;
		end else begin
			if (ex_sleep) begin
				deep_q <= 1'b1;
			end else if (ex_wake) begin
				deep_q <= 1'b0;
			end
			// Leave standby on the edge a cycle starts, so it never overlaps busy
			standby_q <= cs_s[1] && !busy_q && !(ex_prog || ex_sect || ex_blk || ex_chip || ex_srw);
		end
	end

	// Answer shifter: status repeats each byte outside deep power-down, identifier follows sleep-exit
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_q <= 8'h00;
			miso_q <= 1'b0;
		end else if (!cs_low) begin
			tx_q <= 8'h00;
			miso_q <= 1'b0;
		end else if (byte_done) begin
			if (cur_op == OP_STATUS_READ && !deep_q) begin
				tx_q <= sr1;
			end else if (cur_op == OP_SLEEP_EXIT) begin
				tx_q <= DEVICE_ID;
			end else begin
				tx_q <= 8'h00;
			end
		end else if (fall) begin
			miso_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign link.miso = miso_q;
	assign array_addr_o = pa_q;
	assign array_wdata_o = wdata_q;
	assign array_prog_o = prog_q;
	assign array_erase_o = erase_q;
	assign erase_kind_o = kind_q;
	assign busy_o = busy_q;
	assign latch_o = latch_q;
	assign standby_o = standby_q;
	assign deep_o = deep_q;
endmodule
`default_nettype wire

// *** src/fpe_spi_host.sv ***
// Host end: Avalon-MM command registers driving flash frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module fpe_spi_host
	import fpe_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [2:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	fpe_link_if.host link
);
	logic wait_q;
	logic [31:0] rd_q;
	logic [13:0] ctrl_q;
	logic [23:0] addr_q;
	logic [31:0] wdata_q;
	logic [7:0] rdata_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic irq_q;
	logic run_q;
	fpe_hstate_t st_q;
	fpe_frame_t fr_q;
	logic [3:0] div_q;
	logic [6:0] bit_q;
	logic [6:0] len_q;
	logic [63:0] sh_q;
	logic [7:0] rx_q;
	logic [1:0] miso_s;
	logic sclk_q, cs_n_q, mosi_q;

	logic acc, wr_acc, start_req, go, refused, half_end, launch, finish;
	fpe_frame_t nf;
	logic [2:0] nb;
	logic [63:0] ld_sh;
	logic [6:0] ld_len;
	logic [1:0] set_v;

	assign acc = (avs_read_i || avs_write_i) && !wait_q;
	assign wr_acc = acc && avs_write_i;
	assign start_req = wr_acc && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_START];
	assign go = start_req && !run_q;
	assign refused = start_req && run_q;
	assign half_end = div_q == SCLK_HALF - 4'h1;

	// Wait one cycle, then answer; write takes effect on the accepting edge
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_q <= 1'b1;
			rd_q <= 32'h00000000;
		end else if (acc) begin
			wait_q <= 1'b1;
		end else if (avs_read_i || avs_write_i) begin
			wait_q <= 1'b0;
			unique case (avs_address_i)
				REG_CTRL: rd_q <= {run_q, 17'h00000, ctrl_q};
				REG_ADDR: rd_q <= {8'h00, addr_q};
				REG_WDATA: rd_q <= wdata_q;
				REG_RDATA: rd_q <= {24'h000000, rdata_q};
				REG_IRQ_STAT: rd_q <= {30'h00000000, stat_q};
				REG_IRQ_MASK: rd_q <= {30'h00000000, mask_q};
				default: rd_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= 14'h0000;
			addr_q <= 24'h000000;
			wdata_q <= 32'h00000000;
			mask_q <= 2'h0;
		end else if (wr_acc) begin
			if (avs_address_i == REG_CTRL && !run_q) begin
				ctrl_q <= avs_writedata_i[13:0];
			end
			if (avs_address_i == REG_ADDR) begin
				addr_q <= avs_writedata_i[23:0];
			end
			if (avs_address_i == REG_WDATA) begin
				wdata_q <= avs_writedata_i;
			end
			if (avs_address_i == REG_IRQ_MASK) begin
				mask_q <= avs_writedata_i[1:0];
			end
		end
	end

	// Sticky events: a new event wins over a same-cycle clear
	assign set_v = {refused, finish};
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			if (wr_acc && avs_address_i == REG_IRQ_STAT) begin
				stat_q <= (stat_q & ~avs_writedata_i[1:0]) | set_v;
			end else begin
				stat_q <= stat_q | set_v;
			end
			irq_q <= |(stat_q & mask_q);
		end
	end

	// Frame choice: optional unlock, the command itself, then optional status polls
	always_comb begin
		nf = FR_MAIN;
		launch = 1'b0;
		finish = 1'b0;
		if (st_q == HS_IDLE && run_q) begin
			launch = 1'b1;
			nf = ctrl_q[CTRL_AUTO_UNLOCK] ? FR_UNLOCK : FR_MAIN;
		end else if (st_q == HS_GAP && half_end) begin
			unique case (fr_q)
				FR_UNLOCK: launch = 1'b1;
				FR_MAIN: begin
					launch = ctrl_q[CTRL_POLL];
					nf = FR_POLL;
				end
				FR_POLL: begin
					launch = rx_q[SR1_BUSY];
					nf = FR_POLL;
				end
				default: launch = 1'b0;
			endcase
			finish = !launch;
		end
	end

	always_comb begin
		nb = (ctrl_q[10:8] > 3'h4) ? 3'h4 : ctrl_q[10:8];
		ld_sh = {OP_WRITE_UNLOCK, 56'h00000000000000};
		ld_len = 7'h08;
		unique case (nf)
			FR_MAIN: begin
				if (ctrl_q[CTRL_HAS_ADDR]) begin
					ld_sh = {ctrl_q[7:0], addr_q, wdata_q};
					ld_len = 7'h20 + {1'b0, nb, 3'h0};
				end else begin
					ld_sh = {ctrl_q[7:0], wdata_q, 24'h000000};
					ld_len = 7'h08 + {1'b0, nb, 3'h0};
				end
			end
			FR_POLL: begin
				ld_sh = {OP_STATUS_READ, 56'h00000000000000};
				ld_len = 7'h10;
			end
			default: ld_len = 7'h08;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_q <= 1'b0;
		end else if (go) begin
			run_q <= 1'b1;
		end else if (finish) begin
			run_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			miso_s <= 2'h0;
		end else begin
			miso_s <= {miso_s[0], link.miso};
		end
	end

	// Link sequencer, mode 0: data set while clock low, sampled at its rise
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= HS_IDLE;
			fr_q <= FR_MAIN;
			div_q <= 4'h0;
			bit_q <= 7'h00;
			len_q <= 7'h08;
			sh_q <= 64'h0000000000000000;
			rx_q <= 8'h00;
			rdata_q <= 8'h00;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			mosi_q <= 1'b0;
		end else begin
			div_q <= half_end ? 4'h0 : div_q + 4'h1;
			if (launch) begin
				st_q <= HS_LOW;
				fr_q <= nf;
				div_q <= 4'h0;
				bit_q <= 7'h00;
				len_q <= ld_len;
				sh_q <= ld_sh;
				mosi_q <= ld_sh[63];
				cs_n_q <= 1'b0;
			end else begin
				unique case (st_q)
					HS_IDLE: div_q <= 4'h0;
					HS_LOW: if (half_end) begin
						sclk_q <= 1'b1;
						rx_q <= {rx_q[6:0], miso_s[1]};
						st_q <= HS_HIGH;
					end
					HS_HIGH: if (half_end) begin
						sclk_q <= 1'b0;
						bit_q <= bit_q + 7'h01;
						if (bit_q == len_q - 7'h01) begin
							cs_n_q <= 1'b1;
							mosi_q <= 1'b0;
							st_q <= HS_GAP;
							if (fr_q == FR_MAIN) begin
								rdata_q <= rx_q;
							end
						end else begin
							sh_q <= {sh_q[62:0], 1'b0};
							mosi_q <= sh_q[62];
							st_q <= HS_LOW;
						end
					end
					HS_GAP: if (finish) begin
						st_q <= HS_IDLE;
					end
				endcase
			end
		end
	end

	assign avs_readdata_o = rd_q;
	assign avs_waitrequest_o = wait_q;
	assign irq_o = irq_q;
	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.mosi = mosi_q;
endmodule
`default_nettype wire

// *** tb/fpe_link_chk.sv ***
// Assertions on the serial link and the device status outputs
`timescale 1ns/1ps
`default_nettype none
module fpe_link_chk (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic busy_o,
	input wire logic latch_o,
	input wire logic standby_o,
	input wire logic deep_o,
	input wire logic array_prog_o,
	input wire logic array_erase_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_sclk_idle; cs_n |-> !sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("sclk active while deselected");
	property p_sclk_half; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase not 8 cycles");
	property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
	a_cs_gap: assert property (p_cs_gap) else $error("frame gap too short");
	property p_busy_start; $rose(busy_o) |-> cs_n && latch_o; endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy began without latch or inside frame");
	property p_busy_end; $fell(busy_o) |-> !latch_o; endproperty
	a_busy_end: assert property (p_busy_end) else $error("latch kept after busy ended");
	property p_busy_min; $rose(busy_o) |-> busy_o [*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy cycle cut short");
	property p_standby; standby_o |-> !busy_o; endproperty
	a_standby: assert property (p_standby) else $error("standby while busy");
	property p_deep; deep_o |-> !array_prog_o && !array_erase_o && !$rose(busy_o); endproperty
	a_deep: assert property (p_deep) else $error("array touched in deep power-down");
	property p_prog_latch; array_prog_o |-> latch_o; endproperty
	a_prog_latch: assert property (p_prog_latch) else $error("store without write latch");
	c_prog: cover property (array_prog_o);
	c_erase: cover property (array_erase_o);
	c_deep: cover property ($rose(deep_o));
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fpe_pkg::*;
	logic clk = 0, arst_n = 0, rd = 0, wr = 0, upd = 0;
	logic [2:0] adr = 0;
	logic [31:0] wd = 0, rdv, avs_rdata, e;
	logic wreq, irq, busy, latch, stby, deep, prog, erase;
	logic [22:0] aa;
	logic [7:0] awd, ard, d;
	logic [1:0] ek;
	logic [7:0] mem[int];
	logic msk = 0;
	int seed = 72, miscompares = 0, n_checks = 0, a, k;
	logic [7:0] s1[7] = '{8'h1C, 8'h00, 8'h1C, 8'h04, 8'h04, 8'h64, 8'h64};
	logic [7:0] s2[7] = '{8'h00, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
	int ta[7] = '{32'h123400, 32'h123500, 32'h7FF000, 32'h7E0000, 32'h7DFF00, 32'h000100, 32'h001000};
	logic ok[7] = '{0, 0, 1, 1, 0, 1, 0};
	always #5 clk = !clk;
	fpe_link_if lk();
	fpe_spi_host i_fpe_spi_host(.core_clk_i(clk), .arst_n_i(arst_n), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(avs_rdata), .avs_waitrequest_o(wreq),
		.irq_o(irq), .link(lk.host));
	fpe_flash_dev i_fpe_flash_dev(.core_clk_i(clk), .arst_n_i(arst_n), .link(lk.dev), .array_rdata_i(ard),
		.array_addr_o(aa), .array_wdata_o(awd), .array_prog_o(prog), .array_erase_o(erase),
		.erase_kind_o(ek), .busy_o(busy), .latch_o(latch), .standby_o(stby), .deep_o(deep));
	fpe_link_chk i_fpe_link_chk(.core_clk_i(clk), .arst_n_i(arst_n), .sclk(lk.sclk), .cs_n(lk.cs_n),
		.busy_o(busy), .latch_o(latch), .standby_o(stby), .deep_o(deep), .array_prog_o(prog),
		.array_erase_o(erase));
	function automatic logic [7:0] gm(input int x);
		return mem.exists(x) ? mem[x] : 8'hFF;
	endfunction
	// Byte array seen by the device; erased bytes read back as FFh
	always @(aa, upd) ard = gm(int'(aa));
	always @(posedge clk) begin
		int sh;
		sh = (ek == ER_SECTOR) ? 12 : 16;
		if (prog) mem[int'(aa)] = awd;
		if (erase) foreach (mem[x]) if (ek == ER_CHIP || ((x ^ int'(aa)) >> sh) == 0) mem[x] = 8'hFF;
		upd <= upd ^ (prog | erase);
	end
	task automatic complete_run;
		if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
			miscompares++;
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] ad, input logic [31:0] dt);
		int j;
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= ad;
		wd <= dt;
		for (j = 0; j < 50 && wreq !== 1'b0; j++) @(posedge clk);
		if (j == 50) begin
			miscompares++;
			complete_run;
		end
		rdv = avs_rdata;
		wr <= 0;
		rd <= 0;
	endtask
	// Flags are {poll, auto unlock, address}; tw issues a second start while running
	task automatic op(input logic [7:0] o, input logic [2:0] nb, input logic [2:0] fl, input int ad,
		input logic [31:0] dt, input logic tw);
		int j;
		bus(1, REG_ADDR, 32'(ad));
		bus(1, REG_WDATA, dt);
		bus(1, REG_CTRL, {1'b1, 17'h0, fl, nb, o});
		if (tw) bus(1, REG_CTRL, {1'b1, 17'h0, fl, nb, o});
		for (j = 0; j < 4000; j++) begin
			bus(0, REG_IRQ_STAT, 0);
			if (rdv[IRQ_DONE] === 1'b1) break;
		end
		if (j == 4000) begin
			miscompares++;
			complete_run;
		end
		@(posedge clk);
		chk(32'(irq), 32'(msk));
		chk(rdv, {30'h0, tw, 1'b1});
		bus(1, REG_IRQ_STAT, 32'h3);
	endtask
	task automatic pw(input int ad, input logic [7:0] dv, input logic [7:0] x);
		op(OP_PAGE_WRITE, 1, 3'b111, ad, {4{dv}}, 0);
		chk(32'(gm(ad)), 32'(x));
	endtask
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		chk(32'({wreq, irq, busy, latch, deep, stby}), 32'h21);
		a = 32'h100000 + ($random(seed) & 32'h3F0F00);
		d = 8'($random(seed)) & 8'hFE;
		e = $random(seed);
		pw(a, d, d);
		bus(1, REG_IRQ_MASK, 32'h1);
		msk = 1;
		pw(a, e[7:0], d & e[7:0]);
		op(OP_FOUR_K_WIPE, 0, 3'b111, a, 0, 0);
		chk(32'(gm(a)), 32'hFF);
		pw(a + 4096, d, d);
		op(OP_BLOCK_WIPE, 0, 3'b111, a, 0, 0);
		chk(32'(gm(a + 4096)), 32'hFF);
		pw(a, d, d);
		op(OP_CHIP_WIPE, 0, 3'b110, 0, 0, 0);
		chk(32'(gm(a)), 32'hFF);
		for (k = 0; k < 7; k++) begin
			op(OP_STATUS_WRITE, 2, 3'b110, 0, {s1[k], s2[k], 16'h0}, 0);
			d = 8'($random(seed)) & 8'hFE;
			pw(ta[k], d, ok[k] ? d : 8'hFF);
		end
		op(OP_STATUS_WRITE, 2, 3'b110, 0, 0, 0);
		op(OP_SLEEP_ENTER, 0, 3'b000, 0, 0, 0);
		chk(32'(deep), 32'h1);
		op(OP_PAGE_WRITE, 1, 3'b011, a, 0, 0);
		chk(32'(gm(a)), 32'hFF);
		op(OP_SLEEP_EXIT, 1, 3'b000, 0, 0, 0);
		bus(0, REG_RDATA, 0);
		chk(32'(rdv[7:0]), 32'h5A);
		chk(32'(deep), 32'h0);
		op(OP_STATUS_WRITE, 3, 3'b110, 0, 32'h00000400, 0);
		pw(32'h300000, d, 8'hFF);
		op(OP_UNLOCK, 0, 3'b111, 32'h300000, 0, 0);
		pw(32'h300010, d, d);
		pw(32'h310000, d, 8'hFF);
		op(OP_UNLOCK, 0, 3'b111, 0, 0, 0);
		pw(32'h000200, d, d);
		pw(32'h001100, d, 8'hFF);
		op(OP_LOCK, 0, 3'b111, 32'h300000, 0, 0);
		pw(32'h300020, d, 8'hFF);
		op(OP_FOUR_K_WIPE, 0, 3'b111, 32'h200000, 0, 1);
		bus(0, 3'h6, 0);
		chk(rdv, 0);
		complete_run;
	end
endmodule
`default_nettype wire
